// ### mrpr_pkg.sv
// shared constants and state type of the multirate pipeline register
package mrpr_pkg;

   // ------------------------------------------------------------------
   // apb register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RATE = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_OUT = 8'h0c;

   // ------------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------------
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_BASE_BIT = 1;
   localparam int CTRL_CLR_BIT = 2;
   localparam int STAT_LAT_BIT = 16;
   localparam logic [15:0] RATE_RST = 16'h0003;
   localparam logic CTRL_RUN_RST = 1'b1;

   // ------------------------------------------------------------------
   // whole control state of the top level
   // ------------------------------------------------------------------
   typedef struct packed {
      logic run;
      logic base_sel;
      logic clr_pulse;
      logic [15:0] div;
      logic [15:0] div_cnt;
      logic [15:0] load_cnt;
      logic [31:0] prdata;
      logic pslverr;
   } mrpr_state_t;

endpackage : mrpr_pkg

// ### mrpr_chain.sv
// register chain that carries one sample word through a number of stages
`timescale 1ns/1ps
module mrpr_chain #(
   parameter int WIDTH = 16,
   parameter int STAGES = 2
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_load,
   input wire logic i_clear,
   input wire logic [WIDTH-1:0] i_data,
   output logic [WIDTH-1:0] o_data
);

   typedef struct packed {
      logic [STAGES-1:0][WIDTH-1:0] stage;
   } mrpr_chain_t;

   mrpr_chain_t chain_reg;
   mrpr_chain_t chain_next;
   logic [STAGES-1:0][WIDTH-1:0] shifted;

   // ------------------------------------------------------------------
   // shift path
   // ------------------------------------------------------------------
   // chain of stages
   assign shifted[0] = i_data;
   for (genvar g = 1; g < STAGES; g++) begin : g_stage
      assign shifted[g] = chain_reg.stage[g-1];
   end

   // clear beats enable, no load holds every stage
   always_comb begin
      chain_next = chain_reg;
      if (i_clear) begin
         chain_next.stage = '0;
      end else if (i_load) begin
         chain_next.stage = shifted;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         chain_reg <= '0;
      end else begin
         chain_reg <= chain_next;
      end
   end

   assign o_data = chain_reg.stage[STAGES-1];

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   logic src_msb;
   assign src_msb = shifted[STAGES-1][WIDTH-1];

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_first_capture: assert property (i_load && !i_clear
      |=> chain_reg.stage[0] == $past(i_data))
      else $error("first stage did not capture input");
   a_hold_disabled: assert property (!i_load && !i_clear |=> $stable(chain_reg))
      else $error("chain moved while not loading");
   a_clear_zero: assert property (i_clear |=> chain_reg == '0)
      else $error("clear did not zero the chain");
   a_sign_carry: assert property (i_load && !i_clear
      |=> o_data[WIDTH-1] == $past(src_msb))
      else $error("sign bit altered on its way out");

endmodule : mrpr_chain

// ### mrpr_top.sv
// multirate pipeline register: sample chain with apb control
//
// What this block does
// - the input word reaches the output through a chain of at least one register stage.
// - more stages may be chosen to lower the chance of metastability.
// - a clock enable input gates loading only when that build option is on.
// - a synchronous clear input empties all stages only when that build option is on.
// - the output word has exactly the width of the input word, integer plus fraction bits.
// - the sign bit (msb) of a signed word passes through unchanged.
// - stages advance on every base clock edge or, if not selected, on the derived rate.
// - only related rates may be joined; unrelated clocks need a dual-clock fifo outside.
// - going slow to fast, latency should be at least one slow period; fewer stages than div+1 only set the STATUS flag (bit 16).
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module mrpr_top #(
   parameter int INT_BITS = 8,
   parameter int FRAC_BITS = 8,
   parameter int STAGES = 2,
   parameter bit USE_ENA = 1'b1,
   parameter bit USE_SCLR = 1'b1,
   parameter bit USE_BASE_CLOCK = 1'b1
) (
   input wire logic I_CLOCK,
   input wire logic I_RST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic [INT_BITS+FRAC_BITS-1:0] I_DATA,
   input wire logic I_ENA,
   input wire logic I_SCLR,
   output logic [INT_BITS+FRAC_BITS-1:0] O_DATA
);

   localparam int W = INT_BITS + FRAC_BITS;

   initial begin
      if (STAGES < 1) begin
         $error("stage count must be at least one");
      end
   end

   mrpr_pkg::mrpr_state_t state_reg;
   mrpr_pkg::mrpr_state_t state_next;
   logic ena_eff;
   logic sclr_eff;
   logic rate_tick;
   logic load;
   logic lat_short;
   logic [31:0] rd_data;
   logic rd_hit;
   logic wr_acc;

   // ------------------------------------------------------------------
   // enable, clear and rate selection
   // ------------------------------------------------------------------
   // enable only if built in
   assign ena_eff = state_reg.run & (USE_ENA ? I_ENA : 1'b1);
   assign sclr_eff = state_reg.clr_pulse | (USE_SCLR ? I_SCLR : 1'b0);
   assign rate_tick = state_reg.base_sel | (state_reg.div_cnt == 16'h0000);
   assign load = ena_eff & rate_tick;

   assign lat_short = !state_reg.base_sel &&
                      (({1'b0, state_reg.div} + 17'h00001) > 17'(STAGES));

   // ------------------------------------------------------------------
   // register read mux
   // ------------------------------------------------------------------
   always_comb begin
      rd_data = 32'h00000000;
      rd_hit = 1'b1;
      unique case (I_PADDR)
         mrpr_pkg::OFS_CTRL: begin
            rd_data[mrpr_pkg::CTRL_RUN_BIT] = state_reg.run;
            rd_data[mrpr_pkg::CTRL_BASE_BIT] = state_reg.base_sel;
         end
         mrpr_pkg::OFS_RATE: begin
            rd_data[15:0] = state_reg.div;
         end
         mrpr_pkg::OFS_STATUS: begin
            rd_data[15:0] = state_reg.load_cnt;
            rd_data[mrpr_pkg::STAT_LAT_BIT] = lat_short;
         end
         mrpr_pkg::OFS_OUT: begin
            rd_data = 32'(O_DATA);
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // zero wait states: the access phase always completes
   assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.clr_pulse = 1'b0;
      // divider reloads on every rate tick: its own terminal count, or every cycle at base rate
      if (rate_tick) begin
         state_next.div_cnt = state_reg.div;
      end else begin
         state_next.div_cnt = 16'(state_reg.div_cnt - 16'h0001);
      end
      if (load && !sclr_eff) begin
         state_next.load_cnt = 16'(state_reg.load_cnt + 16'h0001);
      end
      // read data latched in setup, so prdata comes from a flop
      if (I_PSEL && !I_PENABLE) begin
         state_next.prdata = rd_hit ? rd_data : 32'h00000000;
         state_next.pslverr = !rd_hit;
      end
      if (wr_acc && I_PADDR == mrpr_pkg::OFS_CTRL) begin
         state_next.run = I_PWDATA[mrpr_pkg::CTRL_RUN_BIT];
         state_next.base_sel = I_PWDATA[mrpr_pkg::CTRL_BASE_BIT];
         state_next.clr_pulse = I_PWDATA[mrpr_pkg::CTRL_CLR_BIT];
      end
      if (wr_acc && I_PADDR == mrpr_pkg::OFS_RATE) begin
         state_next.div = I_PWDATA[15:0];
         state_next.div_cnt = I_PWDATA[15:0]; // restart phase on new rate
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         state_reg <= '{run: mrpr_pkg::CTRL_RUN_RST, base_sel: USE_BASE_CLOCK,
                        clr_pulse: 1'b0, div: mrpr_pkg::RATE_RST,
                        div_cnt: mrpr_pkg::RATE_RST, load_cnt: 16'h0000,
                        prdata: 32'h00000000, pslverr: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign O_PRDATA = state_reg.prdata;
   assign O_PSLVERR = state_reg.pslverr;
   assign O_PREADY = 1'b1;

   // ------------------------------------------------------------------
   // sample chain
   // ------------------------------------------------------------------
   mrpr_chain #(
      .WIDTH(W),
      .STAGES(STAGES)
   ) u_chain (
      .i_clk(I_CLOCK),
      .i_rst_n(I_RST_N),
      .i_load(load),
      .i_clear(sclr_eff),
      .i_data(I_DATA),
      .o_data(O_DATA)
   );

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   int run_cnt;
   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         run_cnt <= 0;
      end else if (load && !sclr_eff) begin
         run_cnt <= (run_cnt < STAGES) ? run_cnt + 1 : STAGES;
      end else begin
         run_cnt <= 0;
      end
   end

   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_RST_N);

   a_chain_latency: assert property (run_cnt == STAGES
      |-> O_DATA == $past(I_DATA, STAGES))
      else $error("output is not the input delayed by the stage count");
   a_ena_gate: assert property (USE_ENA && !I_ENA && !sclr_eff |=> $stable(O_DATA))
      else $error("output moved with enable low");
   a_base_rate: assert property (state_reg.base_sel && ena_eff && !sclr_eff
      |=> state_reg.load_cnt == 16'($past(state_reg.load_cnt) + 16'h0001))
      else $error("base rate missed a load");
   a_div_hold: assert property (!state_reg.base_sel && state_reg.div_cnt != 16'h0000
      |-> !load)
      else $error("derived rate loaded off its tick");
   a_lat_status: assert property (I_PSEL && !I_PENABLE
      && I_PADDR == mrpr_pkg::OFS_STATUS
      |=> O_PRDATA[mrpr_pkg::STAT_LAT_BIT] == $past(lat_short))
      else $error("latency flag misreported");

   c_clear_live: cover property (ena_eff && sclr_eff);
   c_derived_load: cover property (!state_reg.base_sel && load ##1 !load);
   c_full_run: cover property (run_cnt == STAGES);

endmodule : mrpr_top

// ### mrpr_src.sv
// upstream datapath model that feeds sample words to the pipeline register
`timescale 1ns/1ps
module mrpr_src #(
   parameter int W = 16
) (
   input wire logic i_clk,
   input wire logic [W-1:0] i_word,
   input wire logic i_ena,
   input wire logic i_clr,
   output logic [W-1:0] o_data = '0,
   output logic o_ena = 1'b0,
   output logic o_clr = 1'b0
);
   // same related clock
   // launch just after the edge, as a real upstream register would
   always @(posedge i_clk) begin
      o_data <= i_word;
      o_ena <= i_ena;
      o_clr <= i_clr;
   end
endmodule : mrpr_src

// ### multirate_pipeline_register_tb.sv
// self-checking bench for the multirate pipeline register
`timescale 1ns/1ps
module multirate_pipeline_register_tb;
   // ------------------------------------------------------------------
   // signals and reference state
   // ------------------------------------------------------------------
   localparam int W = 16;
   localparam int ST = 3;
   localparam logic [W-1:0] CORNER [3] = '{16'h8000, 16'h7fff, 16'hffff};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic [W-1:0] dat, odat;
   logic [W-1:0] w_word = 16'h0000;
   logic ena, sclr;
   logic w_ena = 1'b0;
   logic w_clr = 1'b0;
   logic run_m = 1'b1;
   logic clr_m = 1'b0;
   logic stream = 1'b0;
   logic [W-1:0] mdl [ST];
   logic [W-1:0] mdl1, odat1;
   logic base_m = 1'b1;
   logic tick_m;
   logic [15:0] div_m, cnt_m;
   logic [31:0] lf = 32'h6a053118;
   int loads = 0;
   int ncyc = 0;
   int miscompares = 0;
   int checks_done = 0;

   always #25 clk = ~clk;

   mrpr_top #(.STAGES(ST)) dut_u (.I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_DATA(dat),
      .I_ENA(ena), .I_SCLR(sclr), .O_DATA(odat));
   mrpr_src #(.W(W)) src_u (.i_clk(clk), .i_word(w_word), .i_ena(w_ena),
      .i_clr(w_clr), .o_data(dat), .o_ena(ena), .o_clr(sclr));
   // second build with its enable and clear build options off (ports still tied), single stage, bus left idle
   mrpr_top #(.STAGES(1), .USE_ENA(1'b0), .USE_SCLR(1'b0)) bare_u (.I_CLOCK(clk),
      .I_RST_N(rst_n), .I_PSEL(1'b0), .I_PENABLE(1'b0), .I_PWRITE(1'b0), .I_PADDR(8'h00),
      .I_PWDATA(32'h0000_0000), .O_PRDATA(), .O_PREADY(), .O_PSLVERR(), .I_DATA(dat),
      .I_ENA(ena), .I_SCLR(sclr), .O_DATA(odat1));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // expected status word: load count and the short-latency flag
   function automatic logic [31:0] stat_exp(input logic b, input logic [15:0] n, input int c);
      return {15'h0000, !b && (int'(n) + 1 > ST), c[15:0]};
   endfunction : stat_exp

   // random words, enable gaps for a slow source, rare clears
   always @(posedge clk) begin
      lf <= lfsr(lf);
      ncyc <= ncyc + (stream ? 1 : 0);
      w_word <= (ncyc < 3) ? CORNER[ncyc] : lf[W-1:0];
      w_ena <= stream & ((ncyc < 3) | lf[17] | lf[18]);
      w_clr <= stream & (ncyc > 3) & (lf[24:20] == 5'h00);
   end

   // reference divider: a tick every div+1 cycles, a rate write restarts it
   assign tick_m = base_m || cnt_m == 16'h0000;
   always @(posedge clk) begin
      if (!rst_n) begin
         div_m <= mrpr_pkg::RATE_RST;
         cnt_m <= mrpr_pkg::RATE_RST;
      end else if (psel && pen && pwr && paddr == mrpr_pkg::OFS_RATE) begin
         div_m <= pwdata[15:0];
         cnt_m <= pwdata[15:0];
      end else begin
         cnt_m <= tick_m ? div_m : cnt_m - 16'h0001;
      end
   end

   // second build ignores enable and clear, so its one stage loads every cycle
   always @(posedge clk) begin
      mdl1 <= rst_n ? dat : 16'h0000;
   end

   // reference chain: clear beats load, no load means hold
   always @(posedge clk) begin
      if (!rst_n || sclr || clr_m) begin
         for (int k = 0; k < ST; k++) mdl[k] <= 16'h0000;
         clr_m <= 1'b0;
         if (!rst_n) loads <= 0;
      end else if (run_m && ena && tick_m) begin
         mdl[0] <= dat;
         for (int k = 1; k < ST; k++) mdl[k] <= mdl[k-1];
         loads <= loads + 1;
      end
   end

   // ------------------------------------------------------------------
   // compare, bus and closing tasks
   // ------------------------------------------------------------------
   task automatic chk_d(input string n, input logic [W-1:0] e, input logic [W-1:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk_d

   task automatic chk_r(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk_r

   task automatic chk_e(input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR PSLVERR expected %b seen %b", e, g);
      end
   endtask : chk_e

   task automatic complete_run;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         miscompares++;
         $display("ERROR PREADY expected 1 seen %b", pready);
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      if (w && a == mrpr_pkg::OFS_CTRL && !err) begin
         run_m <= d[mrpr_pkg::CTRL_RUN_BIT];
         base_m <= d[mrpr_pkg::CTRL_BASE_BIT];
         clr_m <= d[mrpr_pkg::CTRL_CLR_BIT];
      end
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e,
                        input logic ee);
      apb(1'b0, a, 32'h0000_0000);
      chk_r(n, e, rd);
      chk_e(ee, err);
   endtask : rdchk

   // output compared every cycle, away from the clock edge
   always @(negedge clk) begin
      if (rst_n) begin
         chk_d("O_DATA", mdl[ST-1], odat);
         chk_d("O_DATA_BARE", mdl1, odat1);
      end
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rdchk("CTRL", mrpr_pkg::OFS_CTRL, 32'h0000_0003, 1'b0);
      rdchk("RATE", mrpr_pkg::OFS_RATE, 32'h0000_0003, 1'b0);
      rdchk("UNMAPPED", 8'h10, 32'h0000_0000, 1'b1);
      rdchk("UNALIGNED", 8'h02, 32'h0000_0000, 1'b1);
      $display("test reset done");
      stream <= 1'b1;
      repeat (300) @(posedge clk);
      stream <= 1'b0;
      repeat (ST + 3) @(posedge clk);
      rdchk("OUT", mrpr_pkg::OFS_OUT, {16'h0000, mdl[ST-1]}, 1'b0);
      rdchk("STATUS", mrpr_pkg::OFS_STATUS, {16'h0000, loads[15:0]}, 1'b0);
      $display("test stream done");
      // stop loading while words keep coming, then resume
      stream <= 1'b1;
      apb(1'b1, mrpr_pkg::OFS_CTRL, 32'h0000_0002);
      repeat (40) @(posedge clk);
      apb(1'b1, mrpr_pkg::OFS_CTRL, 32'h0000_0003);
      repeat (40) @(posedge clk);
      $display("test hold done");
      // software clear lands amid live traffic
      apb(1'b1, mrpr_pkg::OFS_CTRL, 32'h0000_0007);
      repeat (20) @(posedge clk);
      stream <= 1'b0;
      repeat (ST + 3) @(posedge clk);
      rdchk("CTRL", mrpr_pkg::OFS_CTRL, 32'h0000_0003, 1'b0);
      apb(1'b1, 8'h10, 32'h0000_0000);
      chk_e(1'b1, err);
      rdchk("CTRL", mrpr_pkg::OFS_CTRL, 32'h0000_0003, 1'b0);
      $display("test clear done");
      // derived rate: one load per slow period, latency flag on both sides of its limit
      apb(1'b1, mrpr_pkg::OFS_RATE, 32'h0000_0005);
      rdchk("RATE", mrpr_pkg::OFS_RATE, 32'h0000_0005, 1'b0);
      apb(1'b1, mrpr_pkg::OFS_CTRL, 32'h0000_0001);
      stream <= 1'b1;
      repeat (90) @(posedge clk);
      stream <= 1'b0;
      repeat (ST + 3) @(posedge clk);
      rdchk("STATUS", mrpr_pkg::OFS_STATUS, stat_exp(1'b0, 16'h0005, loads), 1'b0);
      apb(1'b1, mrpr_pkg::OFS_RATE, 32'h0000_0002);
      rdchk("STATUS", mrpr_pkg::OFS_STATUS, stat_exp(1'b0, 16'h0002, loads), 1'b0);
      apb(1'b1, mrpr_pkg::OFS_RATE, 32'h0000_0003);
      rdchk("STATUS", mrpr_pkg::OFS_STATUS, stat_exp(1'b0, 16'h0003, loads), 1'b0);
      $display("test rate done");
      complete_run();
   end
endmodule : multirate_pipeline_register_tb
